// File: mrd_pkg.sv
// constants for the mid-range instruction decode and execute core
package mrd_pkg;
  // instruction groups, top two opcode bits
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT  = 2'h1;
  localparam logic [1:0] GRP_CTL  = 2'h2;
  localparam logic [1:0] GRP_LIT  = 2'h3;
  // byte operation codes, bits 11:8
  localparam logic [3:0] OP_RLC   = 4'hD;
  localparam logic [3:0] OP_RRC   = 4'hC;
  localparam logic [3:0] OP_SUBF  = 4'h2;
  localparam logic [3:0] OP_SWAP  = 4'hE;
  localparam logic [3:0] OP_XORF  = 4'h6;
  localparam logic [3:0] OP_MISC  = 4'h0;
  // low byte of the fixed control words
  localparam logic [7:0] W_CLRWD  = 8'h64;
  localparam logic [7:0] W_SLEEP  = 8'h63;
  localparam logic [7:0] W_RETI   = 8'h09;
  localparam logic [7:0] W_RET    = 8'h08;
  // bit operation codes, bits 11:10
  localparam logic [1:0] BOP_CLR  = 2'h0;
  localparam logic [1:0] BOP_SET  = 2'h1;
  localparam logic [1:0] BOP_SKC  = 2'h2;
  localparam logic [1:0] BOP_SKS  = 2'h3;
  // literal operation codes, bits 11:8; don't-care low bits are zero here
  // and the decoder compares only the upper bits of those codes
  localparam logic [3:0] LIT_ADD  = 4'hE;
  localparam logic [3:0] LIT_SUB  = 4'hC;
  localparam logic [3:0] LIT_AND  = 4'h9;
  localparam logic [3:0] LIT_IOR  = 4'h8;
  localparam logic [3:0] LIT_XOR  = 4'hA;
  localparam logic [3:0] LIT_MOV  = 4'h0;
  localparam logic [3:0] LIT_RET  = 4'h4;
  // file register addresses handled by the core itself
  localparam logic [6:0] FA_TMR   = 7'h01;
  localparam logic [6:0] FA_PCL   = 7'h02;
  localparam logic [6:0] FA_STAT  = 7'h03;
  localparam logic [6:0] FA_PORT  = 7'h06;
  localparam logic [6:0] FA_PCLH  = 7'h0A;
  // status register bit positions
  localparam int SB_C  = 0;
  localparam int SB_DC = 1;
  localparam int SB_Z  = 2;
  // apb register byte offsets and fields
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_CORE   = 8'h04;
  localparam logic [7:0] A_PC     = 8'h08;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_PSA = 1;
  // reset values
  localparam logic [12:0] PC_RST  = 13'h0000;
  localparam logic        RUN_RST = 1'h1;
  localparam logic        PSA_RST = 1'h0;
  // sequencer states
  typedef enum logic [1:0] {ST_EXEC, ST_FLUSH, ST_STBY} mrd_state_e;
endpackage

// File: mrd_core.sv
// instruction decode and execute core with apb control and status access
// Summary of operation
// - rotate left through carry, carry only
// - rotate right through carry, carry only
// - xor w with register, zero flag only
// - bit clear and set, flags untouched
// - skip next when tested bit is clear
// - skip next when tested bit is set
// - add immediate to w, arithmetic flags
// - immediate minus w into w, arithmetic flags
// - or immediate into w, zero flag
// - xor immediate into w, zero flag
// - watchdog clear sets timeout and powerdown flags
// - standby entry, update timeout and powerdown flags
// - interrupt return pops pc, two cycles
// - return pops pc, two cycles, no flags
// - return with immediate loads w and pops
// - destination bit picks w or register
// - port read-modify-write uses pin levels
// - timer count write clears assigned prescaler
// - branches and true skips take two cycles
// - call pushes pc+1, upper bits from latch
//
// Chosen here: the address map and register access over APB.
module mrd_core
  import mrd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [13:0] prog_data,
  output logic      [12:0] prog_addr,
  input  wire logic [7:0]  port_pins,
  output logic      [7:0]  port_latch,
  input  wire logic        wake,
  output logic             standby,
  output logic             wdt_clear,
  output logic             psc_clear,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // core state
  logic [12:0] pc_reg;          // program counter
  logic [7:0]  w_reg;           // working register
  logic        c_reg;           // carry flag
  logic        dc_reg;          // half carry flag
  logic        z_reg;           // zero flag
  logic        to_reg;          // timeout flag
  logic        pd_reg;          // powerdown flag
  logic [4:0]  pch_reg;         // pc high latch
  logic [7:0]  port_reg;        // port output latch
  logic [12:0] stk_mem [0:7];   // return stack, wraps on overflow
  logic [2:0]  sp_reg;          // next free stack slot
  logic [7:0]  ram_mem [0:127]; // general file registers
  mrd_state_e  state_reg;       // sequencer state
  logic        standby_reg;     // standby indication
  logic        wdt_clr_reg;     // watchdog clear pulse
  logic        psc_clr_reg;     // prescaler clear pulse
  // software control
  logic        run_reg;         // core executes while set
  logic        psa_reg;         // prescaler assigned to timer
  // apb answer
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  // decode results
  logic        go;              // an instruction executes this cycle
  logic [6:0]  fa;              // file address field
  logic [2:0]  bsel;            // bit index field
  logic [7:0]  kv;              // eight-bit immediate
  logic [7:0]  bmask;           // one-hot bit mask
  logic [7:0]  fv;              // file operand
  logic [12:0] ret_pc;          // top of stack
  logic [7:0]  res;             // operation result
  logic [9:0]  as;              // adder carry, half carry, sum
  logic        wr_w;            // result goes to w
  logic        wr_f;            // result goes to file register
  logic        upd_c;
  logic        upd_dc;
  logic        upd_z;
  logic        c_n;
  logic        dc_n;
  logic        do_jump;         // pc loaded from tgt
  logic        do_skip;         // next word discarded
  logic        do_push;
  logic        do_pop;
  logic        do_wdt;
  logic        do_sleep;
  logic [12:0] tgt;

  assign go     = run_reg && state_reg == ST_EXEC;
  assign fa     = prog_data[6:0];
  assign bsel   = prog_data[9:7];
  assign kv     = prog_data[7:0];
  assign bmask  = 8'h01 << bsel;
  assign ret_pc = stk_mem[sp_reg - 3'h1];

  // outputs straight from flops
  assign prog_addr  = pc_reg;
  assign port_latch = port_reg;
  assign standby    = standby_reg;
  assign wdt_clear  = wdt_clr_reg;
  assign psc_clear  = psc_clr_reg;
  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;

  // eight-bit add with carry-in, returns {carry, half carry, sum}
  // subtraction is done as a + ~b + 1, so carry means no borrow
  function automatic logic [9:0] mrd_add(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic       cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, cin};
    hi = {1'h0, a[7:4]} + {1'h0, b[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction

  // file operand fetch
  always_comb
  begin
    if (fa == FA_PCL)
      fv = pc_reg[7:0];
    else if (fa == FA_STAT)
      fv = {3'h0, to_reg, pd_reg, z_reg, dc_reg, c_reg};
    else if (fa == FA_PORT)
      fv = port_pins;                 // pins, not latch
    else if (fa == FA_PCLH)
      fv = {3'h0, pch_reg};
    else
      fv = ram_mem[fa];
  end

  // instruction decode; unlisted codes fall through as no_operation
  always_comb
  begin
    res      = fv;
    as       = 10'h000;
    wr_w     = 1'h0;
    wr_f     = 1'h0;
    upd_c    = 1'h0;
    upd_dc   = 1'h0;
    upd_z    = 1'h0;
    do_jump  = 1'h0;
    do_skip  = 1'h0;
    do_push  = 1'h0;
    do_pop   = 1'h0;
    do_wdt   = 1'h0;
    do_sleep = 1'h0;
    tgt      = pc_reg + 13'h0001;
    case (prog_data[13:12])
      GRP_BYTE:
      begin
        case (prog_data[11:8])
          OP_RLC:
          begin
            res   = {fv[6:0], c_reg};
            as[9] = fv[7];
            upd_c = 1'h1;
          end
          OP_RRC:
          begin
            res   = {c_reg, fv[7:1]};
            as[9] = fv[0];
            upd_c = 1'h1;
          end
          OP_SUBF:
          begin
            as     = mrd_add(fv, ~w_reg, 1'h1);
            res    = as[7:0];
            upd_c  = 1'h1;
            upd_dc = 1'h1;
            upd_z  = 1'h1;
          end
          OP_SWAP:
            res = {fv[3:0], fv[7:4]};
          OP_XORF:
          begin
            res   = w_reg ^ fv;
            upd_z = 1'h1;
          end
          default:
            ;
        endcase
        // destination select for the byte operations decoded above
        if (prog_data[11:8] != OP_MISC)
        begin
          if (prog_data[11:8] == OP_RLC || prog_data[11:8] == OP_RRC ||
              prog_data[11:8] == OP_SUBF || prog_data[11:8] == OP_SWAP ||
              prog_data[11:8] == OP_XORF)
          begin
            wr_w = !prog_data[7];
            wr_f = prog_data[7];
          end
        end
        else if (kv == W_CLRWD)
          do_wdt = 1'h1;
        else if (kv == W_SLEEP)
          do_sleep = 1'h1;
        else if (kv == W_RETI || kv == W_RET)
        begin
          do_jump = 1'h1;
          do_pop  = 1'h1;
          tgt     = ret_pc;
        end
      end
      GRP_BIT:
      begin
        case (prog_data[11:10])
          BOP_CLR:
          begin
            res  = fv & ~bmask;
            wr_f = 1'h1;
          end
          BOP_SET:
          begin
            res  = fv | bmask;
            wr_f = 1'h1;
          end
          BOP_SKC:
            do_skip = !fv[bsel];
          default:
            do_skip = fv[bsel];
        endcase
      end
      GRP_CTL:
      begin
        // upper two pc bits always come from the latch
        do_jump = 1'h1;
        tgt     = {pch_reg[4:3], prog_data[10:0]};
        do_push = !prog_data[11];
      end
      default:
      begin
        // codes with don't-care low bits compare only their upper bits
          if (prog_data[11:9] == LIT_ADD[3:1])
          begin
            as     = mrd_add(w_reg, kv, 1'h0);
            res    = as[7:0];
            wr_w   = 1'h1;
            upd_c  = 1'h1;
            upd_dc = 1'h1;
            upd_z  = 1'h1;
          end
          else if (prog_data[11:9] == LIT_SUB[3:1])
          begin
            as     = mrd_add(kv, ~w_reg, 1'h1);
            res    = as[7:0];
            wr_w   = 1'h1;
            upd_c  = 1'h1;
            upd_dc = 1'h1;
            upd_z  = 1'h1;
          end
          else if (prog_data[11:8] == LIT_AND)
          begin
            res   = w_reg & kv;
            wr_w  = 1'h1;
            upd_z = 1'h1;
          end
          else if (prog_data[11:8] == LIT_IOR)
          begin
            res   = w_reg | kv;
            wr_w  = 1'h1;
            upd_z = 1'h1;
          end
          else if (prog_data[11:8] == LIT_XOR)
          begin
            res   = w_reg ^ kv;
            wr_w  = 1'h1;
            upd_z = 1'h1;
          end
          else if (prog_data[11:10] == LIT_MOV[3:2])
          begin
            res  = kv;
            wr_w = 1'h1;
          end
          else if (prog_data[11:10] == LIT_RET[3:2])
          begin
            res     = kv;
            wr_w    = 1'h1;
            do_jump = 1'h1;
            do_pop  = 1'h1;
            tgt     = ret_pc;
          end
      end
    endcase
  end

  assign c_n  = as[9];
  assign dc_n = as[8];

  // sequencer; a jump or true skip adds one discarded no_operation cycle
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pc_reg      <= PC_RST;
      state_reg   <= ST_EXEC;
      standby_reg <= 1'h0;
    end
    else
    begin
      case (state_reg)
        ST_EXEC:
        begin
          if (!run_reg)
            pc_reg <= pc_reg;           // halted by software
          else if (do_sleep)
          begin
            pc_reg      <= pc_reg + 13'h0001;
            state_reg   <= ST_STBY;
            standby_reg <= 1'h1;
          end
          else if (do_jump)
          begin
            pc_reg    <= tgt;
            state_reg <= ST_FLUSH;
          end
          else if (do_skip)
          begin
            pc_reg    <= pc_reg + 13'h0002;
            state_reg <= ST_FLUSH;
          end
          else
            pc_reg <= pc_reg + 13'h0001;
        end
        ST_FLUSH:
          state_reg <= ST_EXEC;         // discarded slot runs as no_operation
        default:
        begin
          if (wake)
          begin
            state_reg   <= ST_EXEC;
            standby_reg <= 1'h0;
          end
        end
      endcase
    end
  end

  // stack pointer; eight levels, wraps silently like the real stack
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      sp_reg <= 3'h0;
    else if (go && do_push)
      sp_reg <= sp_reg + 3'h1;
    else if (go && do_pop)
      sp_reg <= sp_reg - 3'h1;
  end

  // stack storage, no reset needed
  always_ff @(posedge clock)
  begin
    if (go && do_push)
      stk_mem[sp_reg] <= pc_reg + 13'h0001;
  end

  // working register
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      w_reg <= 8'h00;
    else if (go && wr_w)
      w_reg <= res;
  end

  // arithmetic flags; an operation's own update wins over a file write
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      c_reg  <= 1'h0;
      dc_reg <= 1'h0;
      z_reg  <= 1'h0;
    end
    else if (go)
    begin
      if (upd_c)
        c_reg <= c_n;
      else if (wr_f && fa == FA_STAT)
        c_reg <= res[SB_C];
      if (upd_dc)
        dc_reg <= dc_n;
      else if (wr_f && fa == FA_STAT)
        dc_reg <= res[SB_DC];
      if (upd_z)
        z_reg <= (res == 8'h00);
      else if (wr_f && fa == FA_STAT)
        z_reg <= res[SB_Z];
    end
  end

  // timeout and powerdown flags, read-only to file writes
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      to_reg <= 1'h1;
      pd_reg <= 1'h1;
    end
    else if (go && do_wdt)
    begin
      to_reg <= 1'h1;
      pd_reg <= 1'h1;
    end
    else if (go && do_sleep)
    begin
      to_reg <= 1'h1;
      pd_reg <= 1'h0;
    end
  end

  // core file registers; the low pc byte is read-only here
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pch_reg  <= 5'h00;
      port_reg <= 8'h00;
    end
    else if (go && wr_f)
    begin
      if (fa == FA_PCLH)
        pch_reg <= res[4:0];
      else if (fa == FA_PORT)
        port_reg <= res;
    end
  end

  // general file registers
  always_ff @(posedge clock)
  begin
    if (go && wr_f && fa != FA_PCLH && fa != FA_PORT && fa != FA_STAT)
      ram_mem[fa] <= res;
  end

  // one-cycle pulses to the watchdog and timer prescaler
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wdt_clr_reg <= 1'h0;
      psc_clr_reg <= 1'h0;
    end
    else
    begin
      wdt_clr_reg <= go && do_wdt;
      psc_clr_reg <= go && wr_f && fa == FA_TMR && psa_reg;
    end
  end

  // apb answer: pready rises on the second access cycle
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready_reg  <= 1'h0;
      pslverr_reg <= 1'h0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= psel && penable && !pready_reg;
      if (psel && penable && !pready_reg)
      begin
        pslverr_reg <= 1'h0;
        if (paddr == A_CTRL)
          prdata_reg <= {30'h0, psa_reg, run_reg};
        else if (paddr == A_CORE)
          prdata_reg <= {18'h0, standby_reg, to_reg, pd_reg, z_reg,
                         dc_reg, c_reg, w_reg};
        else if (paddr == A_PC)
          prdata_reg <= {13'h0, sp_reg, 3'h0, pc_reg};
        else
        begin
          prdata_reg  <= 32'h0000_0000;   // unmapped answers with an error
          pslverr_reg <= 1'h1;
        end
      end
    end
  end

  // control register write, taken at the completing edge
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run_reg <= RUN_RST;
      psa_reg <= PSA_RST;
    end
    else if (psel && penable && pready_reg && pwrite && paddr == A_CTRL)
    begin
      run_reg <= pwdata[CTRL_RUN];
      psa_reg <= pwdata[CTRL_PSA];
    end
  end

  // checks on the executing core
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  rotl_to_w_a: assert property (
    go && prog_data[13:7] == {GRP_BYTE, OP_RLC, 1'h0}
    |=> w_reg == $past({fv[6:0], c_reg}) && c_reg == $past(fv[7]))
    else $error("rotate left result wrong");
  rotr_carry_a: assert property (
    go && prog_data[13:8] == {GRP_BYTE, OP_RRC} |=> c_reg == $past(fv[0]))
    else $error("rotate right carry wrong");
  xor_zero_a: assert property (
    go && prog_data[13:8] == {GRP_BYTE, OP_XORF}
    |=> ($past(prog_data[7]) || w_reg == $past(w_reg ^ fv))
    && z_reg == ($past(w_reg ^ fv) == 8'h00))
    else $error("xor with register wrong");
  bitop_flags_a: assert property (
    go && prog_data[13:11] == 3'h2 && fa != FA_STAT
    |=> $stable(c_reg) && $stable(z_reg) && $stable(dc_reg))
    else $error("bit operation touched flags");
  skip_clear_a: assert property (
    go && prog_data[13:10] == {GRP_BIT, BOP_SKC} && !fv[bsel]
    |=> state_reg == ST_FLUSH && pc_reg == $past(pc_reg) + 13'h0002
    ##1 state_reg == ST_EXEC)
    else $error("skip on clear not taken");
  skip_set_a: assert property (
    go && prog_data[13:10] == {GRP_BIT, BOP_SKS}
    |=> pc_reg == $past(pc_reg) + ($past(fv[bsel]) ? 13'h0002 : 13'h0001)
    && (state_reg == ST_FLUSH) == $past(fv[bsel]))
    else $error("skip on set taken wrongly");
  add_imm_a: assert property (
    go && prog_data[13:9] == {GRP_LIT, 3'h7} |=> w_reg == $past(w_reg + kv))
    else $error("add immediate wrong");
  watchdog_clr_a: assert property (
    go && prog_data == {GRP_BYTE, OP_MISC, W_CLRWD}
    |=> wdt_clear && to_reg && pd_reg ##1 !wdt_clear)
    else $error("watchdog clear wrong");
  standby_entry_a: assert property (
    go && prog_data == {GRP_BYTE, OP_MISC, W_SLEEP} |=> standby && !pd_reg)
    else $error("standby not entered");
  return_pop_a: assert property (
    go && (prog_data == {GRP_BYTE, OP_MISC, W_RET} ||
           prog_data[13:10] == {GRP_LIT, LIT_RET[3:2]})
    |=> pc_reg == $past(ret_pc) && state_reg == ST_FLUSH
    && sp_reg == $past(sp_reg) - 3'h1)
    else $error("return target wrong");
  call_target_a: assert property (
    go && prog_data[13:11] == {GRP_CTL, 1'h0}
    |=> pc_reg == {$past(pch_reg[4:3]), $past(prog_data[10:0])}
    && sp_reg == $past(sp_reg) + 3'h1)
    else $error("call target wrong");
  psc_clear_a: assert property (
    go && wr_f && fa == FA_TMR && psa_reg |=> psc_clear)
    else $error("prescaler not cleared");

  skip_taken_c: cover property (go && do_skip ##1 state_reg == ST_FLUSH);
  call_ret_c: cover property (go && do_push ##[1:20] go && do_pop);
  standby_wake_c: cover property (standby ##1 wake ##1 !standby);

endmodule

// File: mrd_prog_mem.sv
// program memory model that feeds instruction words to the core
module mrd_prog_mem (
  input  wire logic [12:0] prog_addr,
  output logic      [13:0] prog_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [13:0] mem [0:8191];  // full 8k word space, loaded by the bench
  // asynchronous read: the core samples the word in the same cycle
  assign prog_data = mem[prog_addr];
endmodule

// File: mid_range_instruction_decode_tb_top.sv
// self-checking bench for the decode and execute core
module mid_range_instruction_decode_tb_top
  import mrd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock;          // 20 MHz core clock
  logic        sys_rst;        // async reset, active high
  logic [13:0] prog_data;      // word from program memory
  logic [12:0] prog_addr;      // program counter
  logic [7:0]  port_pins;      // pin levels seen by port reads
  logic [7:0]  port_latch;     // port output latch
  logic        wake;           // leaves standby
  logic        standby;        // core asleep
  logic        wdt_clear;      // watchdog clear pulse
  logic        psc_clear;      // prescaler clear pulse
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          err_total;      // mismatches seen
  int          n_compared;     // comparisons made
  int          n_wdt;          // watchdog pulses
  int          n_psc;          // prescaler pulses
  int          n_cyc;          // cycles to standby
  logic [31:0] rd;             // last read data
  logic        rerr;           // last slave error
  // test program; the skipped words would corrupt w if executed
  logic [13:0] prog [0:20] = '{14'h300F, 14'h3E01, 14'h3A10, 14'h3881, 14'h0686,
    14'h0D06, 14'h0C06, 14'h3CDE, 14'h1806, 14'h3055, 14'h1F86, 14'h3066, 14'h158A,
    14'h2010, 14'h118A, 14'h0064, 14'h0063, 14'h1401, 14'h2020, 14'h2024, 14'h2814};
  mrd_prog_mem mem_i (.prog_addr(prog_addr), .prog_data(prog_data));
  mrd_core uut (.clock(clock), .sys_rst(sys_rst), .prog_data(prog_data),
    .prog_addr(prog_addr), .port_pins(port_pins), .port_latch(port_latch), .wake(wake),
    .standby(standby), .wdt_clear(wdt_clear), .psc_clear(psc_clear), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // clock generation
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // pulse counters on the side outputs
  always @(posedge clock)
  begin
    if (wdt_clear === 1'b1) n_wdt++;
    if (psc_clear === 1'b1) n_psc++;
  end
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one apb transfer from a clock edge; waits for pready, the watchdog bounds a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog against a hung wait
  initial
  begin
    #100000;
    err_total++;
    tally_and_finish();
  end
  // main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, wake} = '0;
    {err_total, n_compared, n_wdt, n_psc, n_cyc} = '0;
    sys_rst = 1'b1;
    port_pins = 8'hBC;
    for (int i = 0; i < 8192; i++) mem_i.mem[i] = 14'h0000;
    for (int i = 0; i < 21; i++) mem_i.mem[i] = prog[i];
    mem_i.mem[13'h0810] = 14'h3442;  // return with 0x42 in w
    // after wake: swap, subtract, and, return, then interrupt return
    mem_i.mem[13'h0020] = 14'h0E06;
    mem_i.mem[13'h0021] = 14'h0206;
    mem_i.mem[13'h0022] = 14'h393C;
    mem_i.mem[13'h0023] = 14'h0008;
    mem_i.mem[13'h0024] = 14'h0009;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    // count executing edges until the standby word takes effect
    do
    begin
      @(posedge clock);
      #1;
      n_cyc++;
    end while (standby !== 1'b1 && n_cyc < 100);
    chk(n_cyc, 20, "cycles to standby");
    chk(port_latch, 8'h3D, "latch from pins");
    // w 0x42, c dc z set by subtract, standby, timeout set, powerdown clear
    apb(1'b0, A_CORE, 0);
    chk(rd, 32'h0000_3742, "core state");
    chk(n_wdt, 1, "watchdog pulse");
    apb(1'b0, A_PC, 0);
    chk(rd, 32'h0000_0011, "pc in standby");
    apb(1'b0, 8'h0C, 0);
    chk(rerr, 1'b1, "unmapped error");
    $display("test 1 done");
    // assign prescaler, wake, then the timer write must clear it once
    apb(1'b1, A_CTRL, 32'h0000_0003);
    apb(1'b0, A_CTRL, 0);
    chk(rd, 32'h0000_0003, "ctrl readback");
    wake <= 1'b1;
    repeat (10) @(posedge clock);
    wake <= 1'b0;
    #1;
    chk(standby, 1'b0, "woken");
    chk(n_psc, 1, "prescaler pulse");
    // w 0x30, carry clear, half carry set, zero clear, timeout set, awake
    apb(1'b0, A_CORE, 0);
    chk(rd, 32'h0000_1230, "core after wake");
    apb(1'b0, A_PC, 0);
    chk(rd, 32'h0000_0014, "jump holds pc");
    $display("test 2 done");
    tally_and_finish();
  end
endmodule
